// ===== fbpbc_map.svh
`ifndef FBPBC_MAP_SVH
`define FBPBC_MAP_SVH

// Command codes on the data bus (low byte).
`define FBPBC_CMD_UNLOCK1      8'hAA
`define FBPBC_CMD_UNLOCK2      8'h55
`define FBPBC_CMD_BC_SETUP     8'hEB
`define FBPBC_CMD_BC_SETUP_ALT 8'h76
`define FBPBC_CMD_BC_CONFIRM   8'h29
`define FBPBC_CMD_RESET        8'hF0
`define FBPBC_CMD_AUTOSEL      8'h90
`define FBPBC_CMD_ERASE_SETUP  8'h80
`define FBPBC_CMD_BLOCK_ERASE  8'h30
`define FBPBC_CMD_PROGRAM      8'hA0
// Unlock addresses for word mode.
`define FBPBC_ADDR_UNLOCK1     24'h000555
`define FBPBC_ADDR_UNLOCK2     24'h0002AA
// Auto-select offset of the block protection status word within a block.
`define FBPBC_ADDR_PROT_OFS    24'h000002
// Protection status codes.
`define FBPBC_PROT_OPEN        8'h00
`define FBPBC_PROT_LOCKED      8'h01
// Data polling register fields.
`define FBPBC_DP_TOGGLE_BIT    6
`define FBPBC_DP_ERROR_BIT     5
// Bus timing: 70 ns access and 50 ns write pulse at 20 ns per cycle.
`define FBPBC_CLK_NS           20
`define FBPBC_T_ACC_NS         70
`define FBPBC_T_WP_NS          50
`define FBPBC_ACC_CYC  ((`FBPBC_T_ACC_NS + `FBPBC_CLK_NS - 1) / `FBPBC_CLK_NS)
`define FBPBC_WP_CYC   ((`FBPBC_T_WP_NS + `FBPBC_CLK_NS - 1) / `FBPBC_CLK_NS)

`endif

// ===== fbpbc_pkg.sv
package fbpbc_pkg;
  typedef enum logic [2:0] {
    FBPBC_OP_READ,
    FBPBC_OP_PROGRAM,
    FBPBC_OP_ERASE,
    FBPBC_OP_BLANK_CHECK,
    FBPBC_OP_PROT_STATUS,
    FBPBC_OP_RESET
  } fbpbc_op_t;

  typedef struct packed {
    fbpbc_op_t   op;
    logic [23:0] addr;
    logic [15:0] data;
  } fbpbc_req_t;

  typedef struct packed {
    logic [15:0] data;
    logic        fail;
    logic        locked;
  } fbpbc_rsp_t;
endpackage

// ===== fbpbc_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "fbpbc_map.svh"

module fbpbc_host
(
  input  wire logic                SYS_CLK_IN,
  input  wire logic                RESETN_IN,
  input  wire logic                REQ_VALID_IN,
  input  wire fbpbc_pkg::fbpbc_req_t REQ_IN,
  input  wire logic                WP_HIGH_IN,
  output logic                     REQ_READY_OUT,
  output logic                     RSP_VALID_OUT,
  output fbpbc_pkg::fbpbc_rsp_t    RSP_OUT,
  output logic                     FLASH_CE_N_OUT,
  output logic                     FLASH_OE_N_OUT,
  output logic                     FLASH_WE_N_OUT,
  output logic                     FLASH_WP_N_OUT,
  output logic [23:0]              FLASH_ADDR_OUT,
  output logic [15:0]              FLASH_DQ_OUT,
  output logic                     FLASH_DQ_OE_OUT,
  input  wire logic [15:0]         FLASH_DQ_IN
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WRITE,
    ST_READ,
    ST_POLL,
    ST_DONE
  } fbpbc_state_t;

  localparam logic [3:0] ACC_CYC = 4'(`FBPBC_ACC_CYC);
  localparam logic [3:0] WP_CYC  = 4'(`FBPBC_WP_CYC);

  function automatic logic [39:0] cyc(input logic [23:0] a, input logic [15:0] d);
    cyc = {a, d};
  endfunction

  fbpbc_state_t          state_reg, state_next;
  fbpbc_pkg::fbpbc_req_t req_reg, req_next;
  logic [39:0]           seq_reg [0:5];
  logic [39:0]           seq_next [0:5];
  logic [2:0]            nseq_reg, nseq_next, idx_reg, idx_next;
  logic [3:0]            cnt_reg, cnt_next;
  logic [15:0]           dq_meta_reg, dq_sync_reg, last_reg, last_next;
  logic                  ready_reg, ready_next, rvalid_reg, rvalid_next;
  fbpbc_pkg::fbpbc_rsp_t rsp_reg, rsp_next;
  logic                  ce_reg, ce_next, oe_reg, oe_next, we_reg, we_next;
  logic                  dqoe_reg, dqoe_next, wp_meta_reg, wp_reg, first_reg, first_next;
  logic [23:0]           addr_reg, addr_next;
  logic [15:0]           dqo_reg, dqo_next;

  default clocking @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (!RESETN_IN);

  always_comb
  begin
    state_next  = state_reg;
    req_next    = req_reg;
    seq_next    = seq_reg;
    nseq_next   = nseq_reg;
    idx_next    = idx_reg;
    cnt_next    = cnt_reg;
    last_next   = last_reg;
    ready_next  = 1'b0;
    rvalid_next = (state_reg == ST_DONE);
    rsp_next    = rsp_reg;
    ce_next     = 1'b1;
    oe_next     = 1'b1;
    we_next     = 1'b1;
    dqoe_next   = 1'b0;
    addr_next   = addr_reg;
    dqo_next    = dqo_reg;
    first_next  = first_reg;
    case (state_reg)
      ST_IDLE:
      begin
        ready_next = !(REQ_VALID_IN && ready_reg);
        if (REQ_VALID_IN && ready_reg)
        begin
          req_next   = REQ_IN;
          idx_next   = 3'h0;
          cnt_next   = 4'h0;
          first_next = 1'b1;
          seq_next[0] = cyc(`FBPBC_ADDR_UNLOCK1, {8'h00, `FBPBC_CMD_UNLOCK1});
          seq_next[1] = cyc(`FBPBC_ADDR_UNLOCK2, {8'h00, `FBPBC_CMD_UNLOCK2});
          case (REQ_IN.op)
            fbpbc_pkg::FBPBC_OP_PROGRAM:
            begin
              seq_next[2] = cyc(`FBPBC_ADDR_UNLOCK1, {8'h00, `FBPBC_CMD_PROGRAM});
              seq_next[3] = cyc(REQ_IN.addr, REQ_IN.data);
              nseq_next = 3'h4;
              state_next = ST_WRITE;
            end
            fbpbc_pkg::FBPBC_OP_ERASE:
            begin
              // The device blank-checks first and may skip the erase; host just polls.
              seq_next[2] = cyc(`FBPBC_ADDR_UNLOCK1, {8'h00, `FBPBC_CMD_ERASE_SETUP});
              seq_next[3] = cyc(`FBPBC_ADDR_UNLOCK1, {8'h00, `FBPBC_CMD_UNLOCK1});
              seq_next[4] = cyc(`FBPBC_ADDR_UNLOCK2, {8'h00, `FBPBC_CMD_UNLOCK2});
              seq_next[5] = cyc(REQ_IN.addr, {8'h00, `FBPBC_CMD_BLOCK_ERASE});
              nseq_next = 3'h6;
              state_next = ST_WRITE;
            end
            fbpbc_pkg::FBPBC_OP_BLANK_CHECK:
            begin
              seq_next[0] = cyc(REQ_IN.addr, {8'h00, `FBPBC_CMD_BC_SETUP});
              seq_next[1] = cyc(REQ_IN.addr, {8'h00, `FBPBC_CMD_BC_CONFIRM});
              nseq_next = 3'h2;
              state_next = ST_WRITE;
            end
            fbpbc_pkg::FBPBC_OP_PROT_STATUS:
            begin
              seq_next[2] = cyc(`FBPBC_ADDR_UNLOCK1, {8'h00, `FBPBC_CMD_AUTOSEL});
              req_next.addr = REQ_IN.addr | `FBPBC_ADDR_PROT_OFS;
              nseq_next = 3'h3;
              state_next = ST_WRITE;
            end
            fbpbc_pkg::FBPBC_OP_RESET:
            begin
              seq_next[0] = cyc(REQ_IN.addr, {8'h00, `FBPBC_CMD_RESET});
              nseq_next = 3'h1;
              state_next = ST_WRITE;
            end
            default:
            begin
              addr_next  = REQ_IN.addr;
              state_next = ST_READ;
            end
          endcase
        end
      end
      ST_WRITE:
      begin
        addr_next = seq_reg[idx_reg][39:16];
        dqo_next  = seq_reg[idx_reg][15:0];
        dqoe_next = 1'b1;
        cnt_next  = cnt_reg + 4'h1;
        // The low phase spans WP_CYC whole cycles so the write pulse is never cut short.
        ce_next   = (cnt_reg == WP_CYC + 4'h2);
        we_next   = (cnt_reg == 4'h0) || (cnt_reg >= WP_CYC + 4'h1);
        if (cnt_reg == WP_CYC + 4'h2)
        begin
          cnt_next = 4'h0;
          idx_next = idx_reg + 3'h1;
          if (idx_reg + 3'h1 == nseq_reg)
          begin
            addr_next = req_reg.addr;
            case (req_reg.op)
              fbpbc_pkg::FBPBC_OP_PROT_STATUS: state_next = ST_READ;
              fbpbc_pkg::FBPBC_OP_RESET:       state_next = ST_DONE;
              default:                         state_next = ST_POLL;
            endcase
          end
        end
      end
      ST_READ, ST_POLL:
      begin
        cnt_next = cnt_reg + 4'h1;
        // Two sync stages add two cycles before the sampled word is valid.
        ce_next  = (cnt_reg == ACC_CYC + 4'h3);
        oe_next  = ce_next;
        if (cnt_reg == ACC_CYC + 4'h3)
        begin
          cnt_next = 4'h0;
          if (state_reg == ST_READ)
          begin
            rsp_next = {dq_sync_reg, 1'b0, (dq_sync_reg[7:0] != `FBPBC_PROT_OPEN)};
            state_next = ST_DONE;
          end
          else
          begin
            last_next  = dq_sync_reg;
            first_next = 1'b0;
            if (!first_reg && (dq_sync_reg[`FBPBC_DP_TOGGLE_BIT] == last_reg[`FBPBC_DP_TOGGLE_BIT]))
            begin
              rsp_next   = {dq_sync_reg, 1'b0, 1'b0};
              state_next = ST_DONE;
            end
            else if (!first_reg && dq_sync_reg[`FBPBC_DP_ERROR_BIT])
            begin
              // Error is latched; the user must send a reset request next.
              rsp_next   = {dq_sync_reg, 1'b1, 1'b0};
              state_next = ST_DONE;
            end
          end
        end
      end
      ST_DONE: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK_IN)
  begin
    dq_meta_reg <= FLASH_DQ_IN;
    dq_sync_reg <= dq_meta_reg;
    wp_meta_reg <= WP_HIGH_IN;
    wp_reg      <= wp_meta_reg;
    seq_reg     <= seq_next;
    req_reg     <= req_next;
    nseq_reg    <= nseq_next;
    idx_reg     <= idx_next;
    cnt_reg     <= cnt_next;
    last_reg    <= last_next;
    first_reg   <= first_next;
    if (!RESETN_IN)
    begin
      state_reg  <= ST_IDLE;
      ready_reg  <= 1'b0;
      rvalid_reg <= 1'b0;
      rsp_reg    <= '0;
      ce_reg     <= 1'b1;
      oe_reg     <= 1'b1;
      we_reg     <= 1'b1;
      dqoe_reg   <= 1'b0;
      addr_reg   <= 24'h000000;
      dqo_reg    <= 16'h0000;
    end
    else
    begin
      state_reg  <= state_next;
      ready_reg  <= ready_next;
      rvalid_reg <= rvalid_next;
      rsp_reg    <= rsp_next;
      ce_reg     <= ce_next;
      oe_reg     <= oe_next;
      we_reg     <= we_next;
      dqoe_reg   <= dqoe_next;
      addr_reg   <= addr_next;
      dqo_reg    <= dqo_next;
    end
  end

  // New requests, including array reads, are only taken in idle, never while polling.
  assign REQ_READY_OUT   = ready_reg;
  assign RSP_VALID_OUT   = rvalid_reg;
  assign RSP_OUT         = rsp_reg;
  assign FLASH_CE_N_OUT  = ce_reg;
  assign FLASH_OE_N_OUT  = oe_reg;
  assign FLASH_WE_N_OUT  = we_reg;
  assign FLASH_WP_N_OUT  = wp_reg;
  assign FLASH_ADDR_OUT  = addr_reg;
  assign FLASH_DQ_OUT    = dqo_reg;
  assign FLASH_DQ_OE_OUT = dqoe_reg;

  property p_no_req_while_polling;
    (state_reg == ST_POLL) |-> !REQ_READY_OUT;
  endproperty
  a_no_req_while_polling: assert property (p_no_req_while_polling)
    else $error("Ready raised during polling.");

  sequence s_bc_start;
    (state_reg == ST_WRITE) && (req_reg.op == fbpbc_pkg::FBPBC_OP_BLANK_CHECK);
  endsequence
  property p_bc_two_writes;
    s_bc_start and (idx_reg == 3'h1) && !we_reg |-> dqo_reg[7:0] == `FBPBC_CMD_BC_CONFIRM;
  endproperty
  a_bc_two_writes: assert property (p_bc_two_writes)
    else $error("Second blank-check cycle is not the confirm code.");

  property p_fail_on_error;
    RSP_VALID_OUT && RSP_OUT.fail |-> RSP_OUT.data[`FBPBC_DP_ERROR_BIT];
  endproperty
  a_fail_on_error: assert property (p_fail_on_error)
    else $error("Failure reported without error bit.");

  property p_wp_follows;
    FLASH_WP_N_OUT == $past(WP_HIGH_IN, 2);
  endproperty
  a_wp_follows: assert property (p_wp_follows)
    else $error("Write-protect output did not follow its input.");
endmodule // fbpbc_host

`default_nettype wire

// ===== fbpbc_flash_model.sv
`timescale 1ns/1ps
`default_nettype none

// Behavioural flash with four blocks of sixteen words, block number in address bits 17:16.
module fbpbc_flash_model
#(
  parameter logic [3:0] NV_INIT    = 4'hF,
  parameter int         BUSY_READS = 3
)
(
  input  wire logic        ce_n_in,
  input  wire logic        oe_n_in,
  input  wire logic        we_n_in,
  input  wire logic        dq_oe_in,
  input  wire logic        wp_n_in,
  input  wire logic [23:0] addr_in,
  input  wire logic [15:0] dq_in,
  output logic      [15:0] dq_out
);
  logic [15:0] mem [64];
  logic [3:0]  nv_bits;
  logic [3:0]  vol_bits;
  logic [15:0] prev;
  logic [15:0] val;
  logic [1:0]  blk;
  logic        tog;
  logic        err;
  int          st;
  int          reads;

  initial
  begin
    foreach (mem[i]) mem[i] = 16'hFFFF;
    nv_bits  = NV_INIT;
    vol_bits = 4'hF;
    prev     = 16'h0000;
    tog      = 1'b0;
    err      = 1'b0;
    st       = 0;
    reads    = 0;
  end

  function automatic logic guarded(input logic [1:0] b);
    return (!wp_n_in && b == 2'h0) || !(nv_bits[b] && vol_bits[b]);
  endfunction

  function automatic logic is_blank(input logic [1:0] b);
    for (int i = 0; i < 16; i++)
      if (mem[{b, 4'(i)}] !== 16'hFFFF) return 1'b0;
    return 1'b1;
  endfunction

  always @(posedge we_n_in)
  begin
    // A write strobe without the host driving the data bus carries no command.
    if (!ce_n_in && dq_oe_in)
    begin
      blk = addr_in[17:16];
      if (st == 1)
      begin
        if (!guarded(blk)) mem[{blk, addr_in[3:0]}] &= dq_in;
        st    = guarded(blk) ? 0 : 5;
        reads = 0;
      end
      else if (dq_in[7:0] == 8'hF0)
      begin
        st  = 0;
        err = 1'b0;
      end
      else if (st == 2 && dq_in[7:0] == 8'h29)
      begin
        err   = !is_blank(blk);
        st    = 5;
        reads = 0;
      end
      else if (st == 3 && dq_in[7:0] == 8'h30)
      begin
        // A blank block is still rewritten to all ones, but it finishes after fewer polls.
        reads = is_blank(blk) ? BUSY_READS - 1 : 0;
        if (!guarded(blk))
          for (int i = 0; i < 16; i++) mem[{blk, 4'(i)}] = 16'hFFFF;
        st = guarded(blk) ? 0 : 5;
      end
      else if (dq_in[7:0] == 8'hEB || dq_in[7:0] == 8'h76) st = 2;
      else if (prev[7:0] == 8'h55 && dq_in[7:0] == 8'hA0) st = 1;
      else if (prev[7:0] == 8'h55 && dq_in[7:0] == 8'h90) st = 4;
      else if (dq_in[7:0] == 8'h80) st = 3;
      prev = dq_in;
    end
  end

  // Chip enable may rise in the same step as output enable, so it is not tested here.
  always @(posedge oe_n_in)
  begin
    if (st == 5)
    begin
      tog   = ~tog;
      reads = err ? reads : reads + 1;
      if (reads >= BUSY_READS) st = 0;
    end
  end

  always_comb
  begin
    val = mem[{addr_in[17:16], addr_in[3:0]}];
    if (st == 5) val = {9'h0, tog, err, 5'h0};
    else if (st == 4 && addr_in[3:0] == 4'h2)
      val = {15'h0, ~(nv_bits[addr_in[17:16]] & vol_bits[addr_in[17:16]])};
    dq_out = (!ce_n_in && !oe_n_in) ? val : ~val;
  end
endmodule // fbpbc_flash_model

`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic                  clk;
  logic                  rst_n;
  logic                  req_valid;
  logic                  wp_high;
  fbpbc_pkg::fbpbc_req_t req;
  fbpbc_pkg::fbpbc_rsp_t rsp;
  fbpbc_pkg::fbpbc_rsp_t got;
  logic                  ready, rsp_valid, ce_n, oe_n, we_n, wp_n, dq_oe;
  logic [23:0]           addr;
  logic [15:0]           dq_o;
  logic [15:0]           dq_i;
  int                    bad_count = 0;
  int                    samples_checked = 0;

  fbpbc_host uut (.SYS_CLK_IN(clk), .RESETN_IN(rst_n), .REQ_VALID_IN(req_valid), .REQ_IN(req),
    .WP_HIGH_IN(wp_high), .REQ_READY_OUT(ready), .RSP_VALID_OUT(rsp_valid), .RSP_OUT(rsp),
    .FLASH_CE_N_OUT(ce_n), .FLASH_OE_N_OUT(oe_n), .FLASH_WE_N_OUT(we_n), .FLASH_WP_N_OUT(wp_n),
    .FLASH_ADDR_OUT(addr), .FLASH_DQ_OUT(dq_o), .FLASH_DQ_OE_OUT(dq_oe), .FLASH_DQ_IN(dq_i));

  fbpbc_flash_model #(.NV_INIT(4'h7), .BUSY_READS(3)) flash (.ce_n_in(ce_n), .oe_n_in(oe_n),
    .we_n_in(we_n), .dq_oe_in(dq_oe), .wp_n_in(wp_n), .addr_in(addr), .dq_in(dq_o),
    .dq_out(dq_i));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic report_and_stop();
    if (bad_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic run_op(input fbpbc_pkg::fbpbc_op_t op, input logic [23:0] a, input logic [15:0] d);
    int n;
    n = 0;
    req_valid <= 1'b1;
    req <= {op, a, d};
    do begin @(posedge clk); n++; end while (ready !== 1'b1 && n < 100);
    req_valid <= 1'b0;
    do begin @(posedge clk); n++; end while (rsp_valid !== 1'b1 && n < 4000);
    if (n >= 4000)
    begin
      bad_count++;
      report_and_stop();
    end
    else
      got = rsp;
  endtask

  task automatic t_program();
    run_op(fbpbc_pkg::FBPBC_OP_PROGRAM, 24'h010003, 16'h1234);
    run_op(fbpbc_pkg::FBPBC_OP_READ, 24'h010003, 16'h0000);
    check("programmed word", 16'h1234, got.data);
    run_op(fbpbc_pkg::FBPBC_OP_READ, 24'h020005, 16'h0000);
    check("erased word", 16'hFFFF, got.data);
  endtask

  task automatic t_blank();
    run_op(fbpbc_pkg::FBPBC_OP_BLANK_CHECK, 24'h010000, 16'h0000);
    check("fail on dirty block", 16'h0001, {15'h0, got.fail});
    run_op(fbpbc_pkg::FBPBC_OP_RESET, 24'h000000, 16'h0000);
    run_op(fbpbc_pkg::FBPBC_OP_READ, 24'h010003, 16'h0000);
    check("read after clear", 16'h1234, got.data);
    run_op(fbpbc_pkg::FBPBC_OP_BLANK_CHECK, 24'h020000, 16'h0000);
    check("fail on blank block", 16'h0000, {15'h0, got.fail});
    run_op(fbpbc_pkg::FBPBC_OP_READ, 24'h020005, 16'h0000);
    check("read after pass", 16'hFFFF, got.data);
  endtask

  task automatic t_erase();
    run_op(fbpbc_pkg::FBPBC_OP_ERASE, 24'h010000, 16'h0000);
    run_op(fbpbc_pkg::FBPBC_OP_BLANK_CHECK, 24'h010000, 16'h0000);
    check("fail after erase", 16'h0000, {15'h0, got.fail});
    run_op(fbpbc_pkg::FBPBC_OP_ERASE, 24'h020000, 16'h0000);
    run_op(fbpbc_pkg::FBPBC_OP_READ, 24'h020005, 16'h0000);
    check("skipped erase", 16'hFFFF, got.data);
  endtask

  task automatic t_protect();
    run_op(fbpbc_pkg::FBPBC_OP_PROGRAM, 24'h030001, 16'h0F0F);
    run_op(fbpbc_pkg::FBPBC_OP_READ, 24'h030001, 16'h0000);
    check("protected word", 16'hFFFF, got.data);
    run_op(fbpbc_pkg::FBPBC_OP_PROT_STATUS, 24'h030000, 16'h0000);
    check("locked status", 16'h0001, {15'h0, got.locked});
    run_op(fbpbc_pkg::FBPBC_OP_PROT_STATUS, 24'h020000, 16'h0000);
    check("open status", 16'h0000, {15'h0, got.locked});
  endtask

  task automatic t_wp();
    wp_high <= 1'b0;
    repeat (4) @(posedge clk);
    check("guard pin low", 16'h0000, {15'h0, wp_n});
    run_op(fbpbc_pkg::FBPBC_OP_PROGRAM, 24'h000001, 16'h0A0A);
    run_op(fbpbc_pkg::FBPBC_OP_READ, 24'h000001, 16'h0000);
    check("guarded word", 16'hFFFF, got.data);
    wp_high <= 1'b1;
    repeat (4) @(posedge clk);
    check("guard pin high", 16'h0001, {15'h0, wp_n});
    run_op(fbpbc_pkg::FBPBC_OP_PROGRAM, 24'h000005, 16'h3C3C);
    run_op(fbpbc_pkg::FBPBC_OP_READ, 24'h000005, 16'h0000);
    check("unguarded word", 16'h3C3C, got.data);
  endtask

  initial
  begin
    rst_n     = 1'b0;
    req_valid = 1'b0;
    req       = '0;
    wp_high   = 1'b1;
    repeat (20) @(posedge clk);
    check("ready in reset", 16'h0000, {15'h0, ready});
    check("strobes in reset", 16'h000E, {12'h0, ce_n, oe_n, we_n, dq_oe});
    rst_n <= 1'b1;
    @(posedge clk);
    t_program();
    t_blank();
    t_erase();
    t_protect();
    t_wp();
    report_and_stop();
  end
endmodule // tb_top

`default_nettype wire
